/* File: rtl/cube_face_select.sv */
// Cube face selection, face-local s and t, and seamless texel addressing.
// Assumes a texture coordinate source upstream and a texel fetch downstream,
// both on ref_clk with valid/ready handshakes.
`timescale 1ns/1ps
// Contract
// RULE_01: Treat inputs as a direction; pick face of largest magnitude axis, keep sign.
// RULE_02: Ties broken deterministically from the three components alone.
// RULE_03: +x: sc=-rz, tc=-ry, ma=rx; -x: sc=rz, tc=-ry, ma=rx.
// RULE_04: +y: sc=rx, tc=rz, ma=ry; -y: sc=rx, tc=-rz, ma=ry.
// RULE_05: +z: sc=rx, tc=-ry, ma=rz; -z: sc=-rx, tc=-ry, ma=rz.
// RULE_06: s = (sc/|ma| + 1)/2 and t = (tc/|ma| + 1)/2.
// RULE_07: Cube sampling ignores programmed wrap modes; fixed seamless addressing only.
// RULE_08: Nearest filtering within a level clamps texel coordinates to the edge.
// RULE_09: Linear filtering within a level always uses border clamping.
// RULE_10: Border in exactly one of u or v fetches from the neighbour face.
// RULE_11: Corner texel is synthesised as the average of three available texels.
// RULE_12: Corner texel equals the common value when the three texels agree.
// RULE_13: Border clamp limits texel coordinates to -1 through face size.
// RULE_14: Edge clamp limits texel coordinates to 0 through face size minus one.
// RULE_15: Face code: +x, -x, +y, -y, +z, -z as 0 to 5.
// RULE_16: Valid/ready in and out; one result per input, in order.
module cube_face_select (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic signed [cube_pkg::COORD_W-1:0] dir_x,
  input wire logic signed [cube_pkg::COORD_W-1:0] dir_y,
  input wire logic signed [cube_pkg::COORD_W-1:0] dir_z,
  input wire logic linear,
  input wire logic [cube_pkg::SIZE_W-1:0] face_size,
  output logic out_valid,
  input wire logic out_ready,
  output cube_pkg::face_t face,
  output logic [cube_pkg::FRAC_W:0] s_coord,
  output logic [cube_pkg::FRAC_W:0] t_coord,
  output logic linear_out,
  output logic [cube_pkg::TEX_N-1:0][2:0] tex_face,
  output logic [cube_pkg::TEX_N-1:0][cube_pkg::SIZE_W-1:0] tex_i,
  output logic [cube_pkg::TEX_N-1:0][cube_pkg::SIZE_W-1:0] tex_j,
  output logic [cube_pkg::TEX_N-1:0] tex_corner,
  output logic [cube_pkg::FRAC_W-1:0] frac_u,
  output logic [cube_pkg::FRAC_W-1:0] frac_v,
  input wire logic avg_valid,
  output logic avg_ready,
  input wire logic [cube_pkg::CH_N*cube_pkg::CH_W-1:0] texel_a,
  input wire logic [cube_pkg::CH_N*cube_pkg::CH_W-1:0] texel_b,
  input wire logic [cube_pkg::CH_N*cube_pkg::CH_W-1:0] texel_c,
  output logic avg_out_valid,
  input wire logic avg_out_ready,
  output logic [cube_pkg::CH_N*cube_pkg::CH_W-1:0] avg_texel
);
  import cube_pkg::*;

  localparam int AW = COORD_W + 1;
  localparam int UW = FRAC_W + SIZE_W + 3;

  state_t state_q;
  logic in_ready_q, out_valid_q, start_q, linear_q;
  face_t face_d, face_q;
  logic [AW-1:0] ax, ay, az, sc_abs_d, tc_abs_d, ma_abs_d;
  logic [AW-1:0] sc_abs_q, tc_abs_q, ma_abs_q;
  logic sc_neg_d, tc_neg_d, sc_neg_q, tc_neg_q;
  logic [SIZE_W-1:0] size_q;
  logic div_done, div_done_t;
  logic [FRAC_W:0] qs, qt, s_q, t_q;
  logic [FRAC_W+1:0] su2, tv2;
  logic [FRAC_W+SIZE_W+1:0] su_p, tv_p;
  logic signed [UW-1:0] u_fx, v_fx;
  logic signed [TC_W-1:0] i0_q, j0_q;
  logic [FRAC_W-1:0] fu_q, fv_q;
  logic signed [TC_W-1:0] ti [TEX_N];
  logic signed [TC_W-1:0] tj [TEX_N];
  face_t af [TEX_N];
  logic [SIZE_W-1:0] ai [TEX_N];
  logic [SIZE_W-1:0] aj [TEX_N];
  logic [TEX_N-1:0] ac;
  logic [TEX_N-1:0][2:0] tex_face_q;
  logic [TEX_N-1:0][SIZE_W-1:0] tex_i_q, tex_j_q;
  logic [TEX_N-1:0] tex_corner_q;
  logic avg_ready_q, avg_valid_q;
  logic [CH_N*CH_W-1:0] avg_q;

  // Magnitudes, one bit wider so the most negative input is exact
  assign ax = dir_x[COORD_W-1] ? AW'(-AW'(dir_x)) : AW'(dir_x);
  assign ay = dir_y[COORD_W-1] ? AW'(-AW'(dir_y)) : AW'(dir_y);
  assign az = dir_z[COORD_W-1] ? AW'(-AW'(dir_z)) : AW'(dir_z);

  // Major axis and projection; ties favour x, then y
  always_comb begin
    if (ax >= ay && ax >= az) begin // see RULE_01 see RULE_02
      face_d = dir_x[COORD_W-1] ? face_neg_x : face_pos_x; // see RULE_15
      ma_abs_d = ax;
      sc_abs_d = az;
      sc_neg_d = dir_x[COORD_W-1] ? dir_z[COORD_W-1] : !dir_z[COORD_W-1]; // see RULE_03
      tc_abs_d = ay;
      tc_neg_d = !dir_y[COORD_W-1];
    end else if (ay >= az) begin
      face_d = dir_y[COORD_W-1] ? face_neg_y : face_pos_y;
      ma_abs_d = ay;
      sc_abs_d = ax;
      sc_neg_d = dir_x[COORD_W-1]; // see RULE_04
      tc_abs_d = az;
      tc_neg_d = dir_y[COORD_W-1] ? !dir_z[COORD_W-1] : dir_z[COORD_W-1];
    end else begin
      face_d = dir_z[COORD_W-1] ? face_neg_z : face_pos_z;
      ma_abs_d = az;
      sc_abs_d = ax;
      sc_neg_d = dir_z[COORD_W-1] ? !dir_x[COORD_W-1] : dir_x[COORD_W-1]; // see RULE_05
      tc_abs_d = ay;
      tc_neg_d = !dir_y[COORD_W-1];
    end
    // Zero magnitudes carry no sign
    if (sc_abs_d == '0) sc_neg_d = 1'b0;
    if (tc_abs_d == '0) tc_neg_d = 1'b0;
  end

  // |sc|/|ma| and |tc|/|ma| side by side, same latency
  cube_frac_div #(.W(AW), .F(FRAC_W)) u_div_s (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(start_q),
    .num(sc_abs_q),
    .den(ma_abs_q),
    .done(div_done),
    .quot(qs)
  );

  cube_frac_div #(.W(AW), .F(FRAC_W)) u_div_t (
    .ref_clk(ref_clk),
    .rst(rst),
    .start(start_q),
    .num(tc_abs_q),
    .den(ma_abs_q),
    .done(div_done_t),
    .quot(qt)
  );

  // Twice s and t, then scaled to texel units; linear centres on texels
  always_comb begin
    su2 = sc_neg_q ? FX_ONE - {1'b0, qs} : FX_ONE + {1'b0, qs}; // see RULE_06
    tv2 = tc_neg_q ? FX_ONE - {1'b0, qt} : FX_ONE + {1'b0, qt};
    // Full-width products; inside a concatenation they would keep only 14 bits
    su_p = su2 * size_q;
    tv_p = tv2 * size_q;
    u_fx = UW'(signed'({1'b0, su_p})) >>> 1;
    v_fx = UW'(signed'({1'b0, tv_p})) >>> 1;
    if (linear_q) begin
      u_fx = u_fx - UW'(FX_HALF);
      v_fx = v_fx - UW'(FX_HALF);
    end
  end

  // Sequence: accept, divide, map, address, present
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= st_idle;
      in_ready_q <= RST_READY;
      out_valid_q <= RST_VALID;
      start_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      case (state_q)
        st_idle: begin
          if (in_valid && in_ready_q) begin // see RULE_16
            in_ready_q <= 1'b0;
            start_q <= 1'b1;
            state_q <= st_div;
          end
        end
        st_div: begin
          if (div_done && div_done_t) state_q <= st_map;
        end
        st_map: state_q <= st_addr;
        st_addr: begin
          out_valid_q <= 1'b1;
          state_q <= st_out;
        end
        st_out: begin
          if (out_ready) begin // see RULE_16
            out_valid_q <= 1'b0;
            in_ready_q <= 1'b1;
            state_q <= st_idle;
          end
        end
        default: state_q <= st_idle;
      endcase
    end
  end

  // Captured request
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      face_q <= face_pos_x;
      sc_abs_q <= '0;
      tc_abs_q <= '0;
      ma_abs_q <= '0;
      sc_neg_q <= 1'b0;
      tc_neg_q <= 1'b0;
      linear_q <= 1'b0;
      size_q <= '0;
    end else if (state_q == st_idle && in_valid && in_ready_q) begin
      face_q <= face_d;
      sc_abs_q <= sc_abs_d;
      tc_abs_q <= tc_abs_d;
      ma_abs_q <= ma_abs_d;
      sc_neg_q <= sc_neg_d;
      tc_neg_q <= tc_neg_d;
      linear_q <= linear;
      size_q <= face_size;
    end
  end

  // Face-local coordinates and base texel
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      t_q <= '0;
      i0_q <= '0;
      j0_q <= '0;
      fu_q <= '0;
      fv_q <= '0;
    end else if (state_q == st_div && div_done) begin
      s_q <= su2[FRAC_W+1:1];
      t_q <= tv2[FRAC_W+1:1];
    end else if (state_q == st_map) begin
      i0_q <= TC_W'(u_fx >>> FRAC_W);
      j0_q <= TC_W'(v_fx >>> FRAC_W);
      fu_q <= u_fx[FRAC_W-1:0];
      fv_q <= v_fx[FRAC_W-1:0];
    end
  end

  // Four-texel footprint; nearest uses texel 0 only; wrap inputs do not exist
  for (genvar k = 0; k < TEX_N; k++) begin : g_tex
    assign ti[k] = i0_q + TC_W'(k % 2);
    assign tj[k] = j0_q + TC_W'(k / 2);
    cube_texel_addr #(.SW(SIZE_W)) u_addr ( // see RULE_10 see RULE_13 see RULE_14
      .face_in(face_q),
      .tex_i(ti[k]),
      .tex_j(tj[k]),
      .size(size_q),
      .wrap(linear_q ? border_clamp_wrap : edge_clamp_wrap), // see RULE_07 see RULE_08 see RULE_09
      .face_out(af[k]),
      .adr_i(ai[k]),
      .adr_j(aj[k]),
      .corner(ac[k])
    );
  end

  // Register the texel addresses for the fetch unit
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      tex_face_q <= '0;
      tex_i_q <= '0;
      tex_j_q <= '0;
      tex_corner_q <= '0;
    end else if (state_q == st_addr) begin
      for (int k = 0; k < TEX_N; k++) begin
        tex_face_q[k] <= af[k];
        tex_i_q[k] <= ai[k];
        tex_j_q[k] <= aj[k];
        tex_corner_q[k] <= ac[k];
      end
    end
  end

  // Corner texel: per-channel average of the three fetched texels
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      avg_ready_q <= RST_READY;
      avg_valid_q <= RST_VALID;
      avg_q <= '0;
    end else if (avg_valid && avg_ready_q) begin
      avg_ready_q <= 1'b0;
      avg_valid_q <= 1'b1;
      for (int c = 0; c < CH_N; c++) begin
        avg_q[c*CH_W +: CH_W] <= CH_W'(((22'(texel_a[c*CH_W +: CH_W]) // see RULE_11
          + 22'(texel_b[c*CH_W +: CH_W]) + 22'(texel_c[c*CH_W +: CH_W]))
          * 22'(AVG_MUL)) >> AVG_SHIFT); // see RULE_12
      end
    end else if (avg_valid_q && avg_out_ready) begin
      avg_valid_q <= 1'b0;
      avg_ready_q <= 1'b1;
    end
  end

  assign in_ready = in_ready_q;
  assign out_valid = out_valid_q;
  assign face = face_q;
  assign s_coord = s_q;
  assign t_coord = t_q;
  assign linear_out = linear_q;
  assign tex_face = tex_face_q;
  assign tex_i = tex_i_q;
  assign tex_j = tex_j_q;
  assign tex_corner = tex_corner_q;
  assign frac_u = fu_q;
  assign frac_v = fv_q;
  assign avg_ready = avg_ready_q;
  assign avg_out_valid = avg_valid_q;
  assign avg_texel = avg_q;
endmodule : cube_face_select

/* File: rtl/cube_frac_div.sv */
// Sequential fraction divider: q = floor(num * 2^F / den), num <= den.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module cube_frac_div #(
  parameter int W = 17,
  parameter int F = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [W-1:0] num,
  input wire logic [W-1:0] den,
  output logic done,
  output logic [F:0] quot
);
  logic [W:0] rem_q;
  logic [F:0] quot_q;
  logic [$clog2(F+2)-1:0] cnt_q;
  logic busy_q;
  logic done_q;
  logic ge;

  assign ge = rem_q >= {1'b0, den};
  assign done = done_q;
  assign quot = quot_q;

  // One quotient bit per cycle, integer bit first
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      cnt_q <= '0;
      rem_q <= '0;
      quot_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (start) begin
        busy_q <= 1'b1;
        cnt_q <= '0;
        rem_q <= {1'b0, num};
        quot_q <= '0;
      end else if (busy_q) begin
        quot_q <= {quot_q[F-1:0], ge};
        rem_q <= ge ? ((rem_q - {1'b0, den}) << 1) : (rem_q << 1);
        cnt_q <= cnt_q + 1'b1;
        if (cnt_q == ($clog2(F+2))'(F)) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end
      end
    end
  end
endmodule : cube_frac_div

/* File: rtl/cube_pkg.sv */
// Shared constants and types for the cube face selection datapath.
// Assumes one 200 MHz clock and fixed-point direction components.
package cube_pkg;

  // Datapath widths
  localparam int COORD_W = 16;
  localparam int FRAC_W = 12;
  localparam int SIZE_W = 12;
  localparam int TC_W = SIZE_W + 2;
  localparam int CH_W = 8;
  localparam int CH_N = 4;
  localparam int TEX_N = 4;

  // Value of one in the quotient's fixed-point form, and one half
  localparam logic [FRAC_W+1:0] FX_ONE = 14'h1000;
  localparam logic [FRAC_W:0] FX_HALF = 13'h0800;

  // Divide by three as multiply and shift, exact for sums below 2048
  localparam logic [11:0] AVG_MUL = 12'h2ab;
  localparam int AVG_SHIFT = 11;

  // Reset values
  localparam logic RST_READY = 1'b1;
  localparam logic RST_VALID = 1'b0;

  // Face codes 0 to 5
  typedef enum logic [2:0] {
    face_pos_x = 3'h0,
    face_neg_x = 3'h1,
    face_pos_y = 3'h2,
    face_neg_y = 3'h3,
    face_pos_z = 3'h4,
    face_neg_z = 3'h5
  } face_t;

  // Texel address clamping flavours
  typedef enum logic {
    edge_clamp_wrap = 1'b0,
    border_clamp_wrap = 1'b1
  } wrap_t;

  // Main sequence, Gray coded from st_idle to st_out; st_out back to st_idle flips two bits
  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_div = 3'h1,
    st_map = 3'h3,
    st_addr = 3'h2,
    st_out = 3'h6
  } state_t;

endpackage : cube_pkg

/* File: rtl/cube_texel_addr.sv */
// Clamps one texel address and moves non-corner border texels onto the neighbour face.
// Purely combinational; the caller registers the results.
`timescale 1ns/1ps
module cube_texel_addr
  import cube_pkg::*;
#(
  parameter int SW = SIZE_W
) (
  input wire face_t face_in,
  input wire logic signed [SW+1:0] tex_i,
  input wire logic signed [SW+1:0] tex_j,
  input wire logic [SW-1:0] size,
  input wire wrap_t wrap,
  output face_t face_out,
  output logic [SW-1:0] adr_i,
  output logic [SW-1:0] adr_j,
  output logic corner
);
  localparam int HW = SW + 3;
  logic signed [HW-1:0] n, lo, hi, ic, jc, a, b, vx, vy, vz, sc, m1;
  logic out_i, out_j;
  logic [1:0] major;

  always_comb begin
    n = HW'(signed'({1'b0, size}));
    m1 = n - HW'(1);
    // Border range -1..N for linear, edge range 0..N-1 for nearest
    lo = (wrap == border_clamp_wrap) ? -HW'(1) : HW'(0); // see RULE_13 see RULE_14
    hi = (wrap == border_clamp_wrap) ? n : m1;
    ic = HW'(tex_i);
    jc = HW'(tex_j);
    if (ic < lo) ic = lo;
    if (ic > hi) ic = hi;
    if (jc < lo) jc = lo;
    if (jc > hi) jc = hi;
    out_i = (ic < 0) || (ic > m1);
    out_j = (jc < 0) || (jc > m1);
    // Half-texel units centred on the face
    a = (ic <<< 1) + HW'(1) - n;
    b = (jc <<< 1) + HW'(1) - n;
    // Back to a cube-space point, inverse of the face projection
    case (face_in)
      face_pos_x: begin vx = n; vy = -b; vz = -a; end
      face_neg_x: begin vx = -n; vy = -b; vz = a; end
      face_pos_y: begin vx = a; vy = n; vz = b; end
      face_neg_y: begin vx = a; vy = -n; vz = -b; end
      face_pos_z: begin vx = a; vy = -b; vz = n; end
      default: begin vx = -a; vy = -b; vz = -n; end
    endcase
    // Old major axis steps in to the edge texel; the crossed axis sits on the edge
    case (face_in[2:1])
      2'h0: vx = vx[HW-1] ? -m1 : m1;
      2'h1: vy = vy[HW-1] ? -m1 : m1;
      default: vz = vz[HW-1] ? -m1 : m1;
    endcase
    if (vx > n) vx = n;
    if (vx < -n) vx = -n;
    if (vy > n) vy = n;
    if (vy < -n) vy = -n;
    if (vz > n) vz = n;
    if (vz < -n) vz = -n;
    major = (vx == n || vx == -n) ? 2'h0 : ((vy == n || vy == -n) ? 2'h1 : 2'h2);
    face_out = face_in;
    adr_i = ic[SW-1:0];
    adr_j = jc[SW-1:0];
    corner = 1'b0;
    sc = a;
    if (wrap == border_clamp_wrap && out_i && out_j) begin
      // Cube corner: no texel here, fetch pinned to the edge, caller averages
      corner = 1'b1; // see RULE_11
      adr_i = (ic < 0) ? '0 : m1[SW-1:0];
      adr_j = (jc < 0) ? '0 : m1[SW-1:0];
    end else if (wrap == border_clamp_wrap && (out_i || out_j)) begin
      // Exactly one axis in the border: read the neighbour face
      case (major) // see RULE_10
        2'h0: begin
          face_out = vx[HW-1] ? face_neg_x : face_pos_x;
          sc = vx[HW-1] ? vz : -vz;
          b = -vy;
        end
        2'h1: begin
          face_out = vy[HW-1] ? face_neg_y : face_pos_y;
          sc = vx;
          b = vy[HW-1] ? -vz : vz;
        end
        default: begin
          face_out = vz[HW-1] ? face_neg_z : face_pos_z;
          sc = vz[HW-1] ? -vx : vx;
          b = -vy;
        end
      endcase
      adr_i = SW'((sc + m1) >>> 1);
      adr_j = SW'((b + m1) >>> 1);
    end
  end
endmodule : cube_texel_addr

/* File: testbench/cube_face_select_assertions.sv */
// Concurrent checks on the ports of the cube face selection block.
// Assumes one clock, ref_clk, and a synchronous active-high reset.
`timescale 1ns/1ps
module cube_face_select_assertions (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic linear,
  input wire logic [11:0] face_size,
  input wire logic out_valid,
  input wire logic out_ready,
  input wire cube_pkg::face_t face,
  input wire logic [12:0] s_coord,
  input wire logic [12:0] t_coord,
  input wire logic linear_out,
  input wire logic [3:0][11:0] tex_i,
  input wire logic [3:0][11:0] tex_j,
  input wire logic [3:0] tex_corner,
  input wire logic avg_valid,
  input wire logic avg_ready,
  input wire logic [31:0] texel_a,
  input wire logic [31:0] texel_b,
  input wire logic [31:0] texel_c,
  input wire logic avg_out_valid,
  input wire logic avg_out_ready,
  input wire logic [31:0] avg_texel
);
  import cube_pkg::*;
  logic [11:0] size_q;
  logic lin_q;
  wire take = in_valid && in_ready;
  wire atake = avg_valid && avg_ready;
  // Settings of the vector in flight
  always_ff @(posedge ref_clk) begin
    if (take) begin
      size_q <= face_size;
      lin_q <= linear;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  AST_TAKE_BUSY: assert property (take |=> !in_ready)
    else $error("in_ready high right after a take");
  AST_LATENCY: assert property (take |-> ##17 !out_valid ##1 out_valid)
    else $error("result not on the seventeenth edge");
  AST_HOLD: assert property (out_valid && !out_ready |=> out_valid
    && $stable(face) && $stable(s_coord) && $stable(t_coord) && $stable(tex_i)
    && $stable(tex_j))
    else $error("result changed while stalled");
  AST_RELEASE: assert property (out_valid && out_ready |=> !out_valid && in_ready)
    else $error("handshake not closed after take of result");
  AST_FACE_CODE: assert property (out_valid |-> face <= face_neg_z)
    else $error("face code out of range");
  AST_ST_RANGE: assert property (out_valid |-> s_coord <= FX_ONE && t_coord <= FX_ONE)
    else $error("s or t above one");
  AST_EDGE_CLAMP: assert property (out_valid && !lin_q |->
    tex_i[0] < size_q && tex_j[0] < size_q)
    else $error("nearest address outside face");
  AST_LIN_COPY: assert property (out_valid |-> linear_out == lin_q)
    else $error("linear_out differs from request");
  AST_REDIRECT: assert property (out_valid && lin_q |-> tex_i[1] < size_q)
    else $error("border texel not moved into a face");
  AST_AVG_TURN: assert property (atake |=> avg_out_valid && !avg_ready)
    else $error("averager answer late");
  AST_AVG_EQUAL: assert property (atake && texel_a == texel_b
    && texel_b == texel_c |=> avg_texel == $past(texel_a))
    else $error("equal texels not preserved");
  AST_AVG_HOLD: assert property (avg_out_valid && !avg_out_ready
    |=> avg_out_valid && $stable(avg_texel))
    else $error("averaged texel changed while stalled");
  // Main scenarios
  cover property (out_valid && linear_out && tex_corner[0]);
  cover property (out_valid && !out_ready ##1 out_valid);
  cover property (avg_out_valid && !avg_out_ready);
endmodule : cube_face_select_assertions

bind cube_face_select cube_face_select_assertions chk_u (.ref_clk, .rst, .in_valid,
  .in_ready, .linear, .face_size, .out_valid, .out_ready, .face, .s_coord, .t_coord,
  .linear_out, .tex_i, .tex_j, .tex_corner, .avg_valid, .avg_ready, .texel_a, .texel_b,
  .texel_c, .avg_out_valid, .avg_out_ready, .avg_texel);

/* File: testbench/fetch_model.sv */
// Texel fetch side: takes results and averaged texels after a stall.
// Assumes the bench sets the stall count; changes follow the falling edge.
`timescale 1ns/1ps
module fetch_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] stall,
  input wire logic out_valid,
  output logic out_ready = 1'b0,
  input wire logic avg_out_valid,
  output logic avg_out_ready = 1'b0
);
  int wcnt = 0;
  int acnt = 0;
  // Accept a result once the stall has run out
  always @(negedge ref_clk) begin
    if (rst || !out_valid) begin
      out_ready <= 1'b0;
      wcnt <= 0;
    end else if (wcnt >= stall) begin
      out_ready <= 1'b1;
    end else begin
      wcnt <= wcnt + 1;
    end
  end
  // Same for the corner averager output
  always @(negedge ref_clk) begin
    if (rst || !avg_out_valid) begin
      avg_out_ready <= 1'b0;
      acnt <= 0;
    end else if (acnt >= stall) begin
      avg_out_ready <= 1'b1;
    end else begin
      acnt <= acnt + 1;
    end
  end
endmodule : fetch_model

/* File: testbench/tb_top.sv */
// Self-checking bench for cube face selection and corner averaging.
// Assumes fetch_model drives both ready inputs of the block.
`timescale 1ns/1ps
module tb_top;
  import cube_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0;
  logic signed [15:0] dir_x = '0, dir_y = '0, dir_z = '0;
  logic linear = 1'b0;
  logic [11:0] face_size = 12'h004;
  logic avg_valid = 1'b0;
  logic [31:0] texel_a = '0, texel_b = '0, texel_c = '0;
  logic [3:0] stall = 4'h0;
  logic in_ready, out_valid, out_ready, linear_out, avg_ready, avg_out_valid, avg_out_ready;
  face_t face;
  logic [12:0] s_coord, t_coord;
  logic [3:0][2:0] tex_face;
  logic [3:0][11:0] tex_i, tex_j;
  logic [3:0] tex_corner;
  logic [11:0] frac_u, frac_v;
  logic [31:0] avg_texel;
  int miscompares = 0;
  int samples_checked = 0;

  // Clock
  always #2.5 ref_clk = ~ref_clk;

  cube_face_select dut_u (.ref_clk, .rst, .in_valid, .in_ready, .dir_x, .dir_y, .dir_z,
    .linear, .face_size, .out_valid, .out_ready, .face, .s_coord, .t_coord, .linear_out,
    .tex_face, .tex_i, .tex_j, .tex_corner, .frac_u, .frac_v, .avg_valid, .avg_ready,
    .texel_a, .texel_b, .texel_c, .avg_out_valid, .avg_out_ready, .avg_texel);
  fetch_model model_u (.ref_clk, .rst, .stall, .out_valid, .out_ready, .avg_out_valid,
    .avg_out_ready);

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // Offer one vector, wait for its result; returns with the result standing
  task automatic send(input int x, input int y, input int z, input logic lin);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (in_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    in_valid = 1'b1;
    dir_x = 16'(x);
    dir_y = 16'(y);
    dir_z = 16'(z);
    linear = lin;
    @(negedge ref_clk);
    in_valid = 1'b0;
    n = 0;
    while (out_valid !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    chk(32'(n), 32'd17);
  endtask : send

  // Expected face and s,t in 1.12 fixed point, x before y before z on ties
  function automatic void ref_map(input int x, y, z, output int f, s, t);
    int ax, ay, az, sc, tc, ma;
    ax = x < 0 ? -x : x;
    ay = y < 0 ? -y : y;
    az = z < 0 ? -z : z;
    if (ax >= ay && ax >= az) begin
      f = x < 0;
      sc = x < 0 ? z : -z;
      tc = -y;
      ma = ax;
    end else if (ay >= az) begin
      f = 2 + (y < 0);
      sc = x;
      tc = y < 0 ? -z : z;
      ma = ay;
    end else begin
      f = 4 + (z < 0);
      sc = z < 0 ? -x : x;
      tc = -y;
      ma = az;
    end
    s = (sc < 0 ? 4096 - (-sc * 4096 / ma) : 4096 + sc * 4096 / ma) / 2;
    t = (tc < 0 ? 4096 - (-tc * 4096 / ma) : 4096 + tc * 4096 / ma) / 2;
  endfunction : ref_map

  task automatic test_faces();
    int v[8][3] = '{'{400, -100, 200}, '{-400, 100, -200}, '{100, 400, -200},
      '{100, -400, 200}, '{-200, 100, 400}, '{200, -100, -400}, '{300, -300, 100},
      '{0, 200, -200}};
    int f, s, t;
    for (int i = 0; i < 8; i++) begin
      stall = 4'(i);
      send(v[i][0], v[i][1], v[i][2], 1'b0);
      ref_map(v[i][0], v[i][1], v[i][2], f, s, t);
      chk(32'(face), 32'(f));
      chk(32'(s_coord), 32'(s));
      chk(32'(t_coord), 32'(t));
    end
    $display("test_faces done");
  endtask : test_faces

  task automatic test_nearest();
    stall = 4'h2;
    send(100, 0, -100, 1'b0);
    chk(32'(s_coord), 32'h1000);
    chk(32'(tex_i[0]), 32'd3);
    chk(32'(tex_j[0]), 32'd2);
    send(100, 0, 100, 1'b0);
    chk(32'(tex_i[0]), 32'd0);
    $display("test_nearest done");
  endtask : test_nearest

  task automatic test_linear();
    send(100, 0, -100, 1'b1);
    chk(32'(linear_out), 32'd1);
    chk(32'(tex_i[0]), 32'd3);
    chk(32'(tex_j[0]), 32'd1);
    chk(32'(frac_u), 32'h800);
    chk(32'(frac_v), 32'h800);
    chk(32'(tex_face[1]), 32'(face_neg_z));
    chk(32'(tex_corner), 32'h0);
    send(100, 100, 100, 1'b1);
    chk(32'(tex_corner), 32'h1);
    chk(32'(tex_face[1]), 32'(face_pos_y));
    chk(32'(tex_face[2]), 32'(face_pos_z));
    chk(32'({tex_face[3], tex_i[3], tex_j[3]}), 32'h0);
    $display("test_linear done");
  endtask : test_linear

  // Offer three texels and judge the averaged one
  task automatic avg(input logic [31:0] a, b, c, e);
    int n;
    n = 0;
    @(negedge ref_clk);
    while (avg_ready !== 1'b1 && n < 50) begin
      @(negedge ref_clk);
      n++;
    end
    avg_valid = 1'b1;
    texel_a = a;
    texel_b = b;
    texel_c = c;
    @(negedge ref_clk);
    avg_valid = 1'b0;
    chk(32'(avg_out_valid), 32'd1);
    chk(avg_texel, e);
  endtask : avg

  task automatic test_average();
    stall = 4'h3;
    avg(32'h11223344, 32'h11223344, 32'h11223344, 32'h11223344);
    avg(32'h01020304, 32'h02030405, 32'h030404ff, 32'h02030358);
    avg(32'hffffffff, 32'hffffffff, 32'h00000000, 32'haaaaaaaa);
    $display("test_average done");
  endtask : test_average

  task automatic finish_test();
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  // Main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    rst = 1'b0;
    test_faces();
    test_nearest();
    test_linear();
    test_average();
    finish_test();
  end

  // Watchdog well beyond the expected run
  initial begin
    #50000;
    miscompares++;
    finish_test();
  end
endmodule : tb_top
